// [common/mrs_defs.vh]
/*
  Constants of the multi-region readout sequencer: link codes, table
  size, reset values and timing counts at the 40 MHz system clock.
  Assumes it is included by bare name into the design file.
*/
`ifndef MRS_DEFS_VH
`define MRS_DEFS_VH

// Table size
`define MRS_MAX_ROWS 4'h8

// Link control character and header words
`define MRS_KCHAR 16'h000A
`define MRS_HDR_CFG 16'h0000
`define MRS_HDR_RST 16'h0052

// Reset values
`define MRS_CC_RST 8'h00
`define MRS_CPR_RST 24'h00_0001

// Clock and timing, times in ns
`define MRS_CLK_MHZ 40
`define MRS_COORD_NS 2500
`define MRS_COORD_CYC ((`MRS_COORD_NS * `MRS_CLK_MHZ) / 1000)
// Last cycle of one corner slot, 100 cycles less one, at counter width
`define MRS_COORD_LAST 8'h63
`define MRS_PIX_NS 6000
`define MRS_PIX_CYC ((`MRS_PIX_NS * `MRS_CLK_MHZ) / 1000)
// Last cycle of one pixel slot, 240 cycles less one, at counter width
`define MRS_PIX_LAST 8'hEF

// 25 MHz delay tick from 40 MHz: add 5 per cycle modulo 8
`define MRS_TICK_NUM 4'h5
`define MRS_TICK_DEN 4'h8

`endif

// [dv/mrs_far_end.sv]
/* Far side: multiplexer corner port, pixel converter, link receiver.
   Assumes design outputs are registers on i_sys_clk. */
`timescale 1ns/1ps
module mrs_far_end (
  input wire i_sys_clk,
  input wire i_coord_strobe,
  input wire [23:0] i_coord_word,
  input wire i_pix_strobe,
  input wire [11:0] i_pix_col,
  input wire [11:0] i_pix_row,
  input wire i_link_valid,
  input wire i_link_k,
  input wire [15:0] i_link_data,
  output wire [15:0] o_pixel_data
);
  logic [23:0] corners [$];
  logic [16:0] words [$];
  // sample at strobe; inverted elsewhere so a late read shows
  assign o_pixel_data = {i_pix_row[7:0], i_pix_col[7:0]} ^ {16{~i_pix_strobe}};
  // logs corners, keeps flag with each word
  always @(posedge i_sys_clk) begin
    if (i_coord_strobe) corners.push_back(i_coord_word);
    if (i_link_valid) words.push_back({i_link_k, i_link_data});
  end
endmodule // mrs_far_end

// [dv/mrs_seq_checker.sv]
/* Port checker for the readout sequencer.
   Assumes one clock, i_sys_clk, and async active-low i_rstn. */
`timescale 1ns/1ps
`include "mrs_defs.vh"
module mrs_seq_checker (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_video_on,
  input wire i_row_wr,
  input wire o_cmd_poll,
  input wire o_full_frame,
  input wire o_global_reset,
  input wire o_coord_strobe,
  input wire o_pix_strobe,
  input wire o_link_valid,
  input wire o_link_k,
  input wire [15:0] o_link_data,
  input wire [7:0] o_config_count,
  input wire o_busy
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  //////////////////////////////////////
  // Corner count and pixel gap; gap saturates so long idles never wrap
  reg [1:0] ncor;
  reg [8:0] pgap;
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ncor <= 2'h0;
      pgap <= 9'h1FF;
    end else begin
      if (o_coord_strobe) ncor <= ncor + 2'h1;
      if (o_pix_strobe) pgap <= 9'h000;
      else if (pgap != 9'h1FF) pgap <= pgap + 9'h001;
    end
  end
  //////////////////////////////////////
  AST_IDLE: assert property (
    !o_busy && !i_video_on |=> !o_busy && !o_link_valid)
    else $error("activity with video off");
  AST_POLL: assert property (
    !o_busy && i_video_on |=> o_cmd_poll)
    else $error("no poll at pass start");
  AST_RST: assert property (
    o_cmd_poll |=> o_full_frame && o_global_reset && o_link_k)
    else $error("reset step missing");
  AST_HDR: assert property (
    o_cmd_poll |=> ##1 (!o_link_k && o_link_data == `MRS_HDR_RST)
    ##1 o_link_k ##1 (o_link_data == `MRS_HDR_CFG)
    ##1 (o_link_data == {8'h00, o_config_count}))
    else $error("bad packet headers");
  AST_K: assert property (
    o_link_k |-> o_link_valid && o_link_data == `MRS_KCHAR)
    else $error("bad control word");
  AST_CC: assert property (
    i_row_wr |=> o_config_count == $past(o_config_count) + 8'h01)
    else $error("config counter not bumped");
  AST_COORD: assert property (
    o_coord_strobe && ncor != 2'h3 |-> ##100 o_coord_strobe)
    else $error("corner spacing wrong");
  AST_CLR: assert property (
    o_coord_strobe |-> !o_global_reset && !o_full_frame)
    else $error("reset held into region");
  AST_PIX: assert property (
    o_pix_strobe |-> pgap >= 9'h0EF)
    else $error("pixel rate too fast");
endmodule // mrs_seq_checker

bind mrs_sequencer mrs_seq_checker u_mrs_seq_checker (.i_sys_clk, .i_rstn,
  .i_video_on, .i_row_wr, .o_cmd_poll, .o_full_frame, .o_global_reset,
  .o_coord_strobe, .o_pix_strobe, .o_link_valid, .o_link_k, .o_link_data,
  .o_config_count, .o_busy);

// [dv/test_mrs_sequencer.sv]
/* Bench: loads the region table, runs one video pass, compares corner
   words and link stream. Assumes the 40 MHz clock made here. */
`timescale 1ns/1ps
module test_mrs_sequencer;
  logic i_sys_clk, i_rstn, i_video_on, i_row_wr, i_cpr_wr;
  logic [2:0] i_row_index;
  logic [11:0] i_row_period, i_row_col, i_row_start, i_row_ncol, i_row_nrow;
  logic [23:0] i_row_delay, i_cpr_value, o_coord_word;
  logic [15:0] i_pixel_data, o_link_data;
  logic o_cmd_poll, o_full_frame, o_global_reset, o_coord_strobe, o_busy;
  logic o_pix_strobe, o_link_valid, o_link_k;
  logic [11:0] o_pix_col, o_pix_row;
  logic [3:0] o_active_count;
  logic [7:0] o_config_count;
  int miscompares = 0;
  int cmp_count = 0;
  logic [16:0] exp_w [$];
  logic [23:0] exp_c [$];
  logic [16:0] pre [17] = '{17'h1_000A, 17'h0_0052, 17'h1_000A, 17'h0_0000,
    17'h0_0009, 17'h0_0001, 17'h0_0000, 17'h0_000A, 17'h0_0014, 17'h0_0002,
    17'h0_0001, 17'h0_0002, 17'h0_0005, 17'h0_001E, 17'h0_0028, 17'h0_0001,
    17'h0_0002};
  mrs_sequencer u_mrs_sequencer (.i_sys_clk, .i_rstn, .i_video_on,
    .i_row_wr, .i_row_index, .i_row_period, .i_row_delay, .i_row_col,
    .i_row_start, .i_row_ncol, .i_row_nrow, .i_cpr_wr, .i_cpr_value,
    .i_pixel_data, .o_cmd_poll, .o_full_frame, .o_global_reset,
    .o_coord_word, .o_coord_strobe, .o_pix_strobe, .o_pix_col, .o_pix_row,
    .o_link_valid, .o_link_k, .o_link_data, .o_active_count,
    .o_config_count, .o_busy);
  mrs_far_end u_mrs_far_end (.i_sys_clk, .i_coord_strobe(o_coord_strobe),
    .i_coord_word(o_coord_word), .i_pix_strobe(o_pix_strobe),
    .i_pix_col(o_pix_col), .i_pix_row(o_pix_row), .i_link_k(o_link_k),
    .i_link_valid(o_link_valid), .i_link_data(o_link_data),
    .o_pixel_data(i_pixel_data));
  //////////////////////////////////////
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  // Watchdog well beyond the one pass of some 3000 cycles
  initial begin
    #500000;
    miscompares++;
    end_sim();
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr_row(logic [2:0] ix, logic [11:0] p, logic [23:0] d,
                        logic [11:0] c, r, nc, nr);
    @(posedge i_sys_clk) #2;
    {i_row_index, i_row_period, i_row_delay} = {ix, p, d};
    {i_row_col, i_row_start, i_row_ncol, i_row_nrow} = {c, r, nc, nr};
    i_row_wr = 1'b1;
    @(posedge i_sys_clk) #2;
    i_row_wr = 1'b0;
  endtask
  // Corners TL TR BL BR, then K, header and raster, column fastest
  task automatic region(logic [15:0] n, logic [11:0] c, r, nc, nr);
    logic [11:0] ry, cx;
    exp_c.push_back({r, c});
    exp_c.push_back({r, c + nc - 12'h001});
    exp_c.push_back({r + nr - 12'h001, c});
    exp_c.push_back({r + nr - 12'h001, c + nc - 12'h001});
    exp_w.push_back(17'h1_000A);
    exp_w.push_back({1'b0, n});
    for (int y = 0; y < nr; y++)
      for (int x = 0; x < nc; x++) begin
        ry = r + y[11:0];
        cx = c + x[11:0];
        exp_w.push_back({1'b0, ry[7:0], cx[7:0]});
      end
  endtask
  //////////////////////////////////////
  initial begin
    {i_rstn, i_video_on, i_row_wr, i_cpr_wr, i_row_index} = 7'h00;
    {i_row_period, i_row_col, i_row_start} = 36'h0_0000_0000;
    {i_row_ncol, i_row_nrow, i_row_delay, i_cpr_value} = 72'h0;
    repeat (12) @(posedge i_sys_clk);
    #2 i_rstn = 1'b1;
    check("config_count", o_config_count, 32'h0);
    check("active_count", o_active_count, 32'h0);
    wr_row(3'h0, 12'h001, 24'h00_0000, 12'h00A, 12'h014, 12'h002, 12'h001);
    wr_row(3'h1, 12'h002, 24'h00_0005, 12'h01E, 12'h028, 12'h001, 12'h002);
    for (int i = 2; i < 8; i++)
      wr_row(i[2:0], 12'h001, 24'h0, 12'h005, 12'h005, 12'h001, 12'h001);
    @(posedge i_sys_clk) #2;
    check("full table", o_active_count, 32'h8);
    wr_row(3'h2, 12'h000, 24'h0, 12'h0, 12'h0, 12'h0, 12'h0);
    @(posedge i_sys_clk) #2;
    check("early end", o_active_count, 32'h2);
    check("config_count", o_config_count, 32'h9);
    $display("table test done");
    // cycle count has its own write
    i_cpr_value = 24'h00_0002;
    i_cpr_wr = 1'b1;
    @(posedge i_sys_clk) #2;
    i_cpr_wr = 1'b0;
    foreach (pre[j]) exp_w.push_back(pre[j]);
    region(16'h0001, 12'h00A, 12'h014, 12'h002, 12'h001);
    region(16'h0001, 12'h00A, 12'h014, 12'h002, 12'h001);
    region(16'h0002, 12'h01E, 12'h028, 12'h001, 12'h002);
    i_video_on = 1'b1;
    // Poll stands for the one cycle after video on is taken
    @(posedge i_sys_clk) #2;
    check("poll", o_cmd_poll, 32'h1);
    i_video_on = 1'b0;
    for (int t = 0; t < 8000 && o_busy !== 1'b0; t++) @(posedge i_sys_clk);
    repeat (20) @(posedge i_sys_clk);
    check("idle", o_busy, 32'h0);
    check("words", u_mrs_far_end.words.size(), exp_w.size());
    foreach (exp_w[j])
      check("link", u_mrs_far_end.words[j], exp_w[j]);
    check("corners", u_mrs_far_end.corners.size(), exp_c.size());
    foreach (exp_c[j])
      check("corner", u_mrs_far_end.corners[j], exp_c[j]);
    $display("stream test done");
    end_sim();
  end
endmodule // test_mrs_sequencer

// [logic/mrs_sequencer.v]
/*
  Multi-region readout sequencer: region table, global reset and
  configuration packets, per-region coordinate load, raster read and
  post-read delay. Assumes all inputs come from logic on i_sys_clk
  (command decoder and pixel converter), so none are synchronised.
*/
// Functional notes
// - Table holds up to eight region rows, each a full window.
// - Regions are visited in row order, first row first.
// - One row write command stores one whole table row.
// - A zero sample_period is never sampled and ends the table.
// - Region sampled on iteration i when i mod sample_period is zero.
// - active_region_count is the number of rows before first zero.
// - With video off the sequencer idles once the current pass ends, no resets, reads or packets.
// - Each pass: full frame, global reset, config packet, release.
// - Iterations 1..cycle count: coordinates, read, then delay.
// - Cycle count has its own write command and is held.
// - Host command polled once per pass, at the reset point.
// - post_read_delay is 24 bits of 40 ns ticks, zero no wait.
// - Four corner words sent serially, 2.5 us each, before a read.
// - Raster of the region is read before the next is programmed.
// - Regions read one at a time through one channel.
// - Every link packet begins with the control character.
// - Header after control: 00 config, 01..08 region, 52 reset.
// - Config counter from zero, bumps on row change, sent after 00.
// - Pixels read at a fixed 6 us rate.
`timescale 1ns/1ps
`include "mrs_defs.vh"

module mrs_sequencer (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_video_on,
  input wire i_row_wr,
  input wire [2:0] i_row_index,
  input wire [11:0] i_row_period,
  input wire [23:0] i_row_delay,
  input wire [11:0] i_row_col,
  input wire [11:0] i_row_start,
  input wire [11:0] i_row_ncol,
  input wire [11:0] i_row_nrow,
  input wire i_cpr_wr,
  input wire [23:0] i_cpr_value,
  input wire [15:0] i_pixel_data,
  output reg o_cmd_poll,
  output reg o_full_frame,
  output reg o_global_reset,
  output reg [23:0] o_coord_word,
  output reg o_coord_strobe,
  output reg o_pix_strobe,
  output reg [11:0] o_pix_col,
  output reg [11:0] o_pix_row,
  output reg o_link_valid,
  output reg o_link_k,
  output reg [15:0] o_link_data,
  output reg [3:0] o_active_count,
  output reg [7:0] o_config_count,
  output wire o_busy
);

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_RST = 3'd1;
  localparam [2:0] S_ITER = 3'd2;
  localparam [2:0] S_COORD = 3'd3;
  localparam [2:0] S_HDR = 3'd4;
  localparam [2:0] S_PIX = 3'd5;
  localparam [2:0] S_DELAY = 3'd6;
  localparam [7:0] COORD_LAST = `MRS_COORD_LAST;
  localparam [7:0] PIX_LAST = `MRS_PIX_LAST;

  // Region table, one entry per row
  reg [11:0] t_per [0:7];
  reg [23:0] t_dly [0:7];
  reg [11:0] t_col [0:7];
  reg [11:0] t_row [0:7];
  reg [11:0] t_ncol [0:7];
  reg [11:0] t_nrow [0:7];
  reg [11:0] phase [0:7];
  reg [23:0] cpr;

  reg [2:0] state;
  reg [23:0] iter;
  reg [3:0] cur;
  reg [3:0] wcnt;
  reg [3:0] crow;
  reg [2:0] fld;
  reg [1:0] corner;
  reg [7:0] cyc;
  reg [11:0] col;
  reg [11:0] row;
  reg [23:0] dly;
  reg [3:0] frac;
  reg [3:0] next_count;
  reg stop;
  // One loop index per process so no variable has two drivers
  integer kc;
  integer kt;
  integer ks;

  wire [2:0] ci = cur[2:0];
  wire [11:0] ph_nxt = phase[ci] + 12'h001;
  wire [3:0] frac_sum = frac + `MRS_TICK_NUM;
  wire tick = (frac_sum >= `MRS_TICK_DEN);

  assign o_busy = (state != S_IDLE);

  ////////////////////////////////////////////////////////////////////
  // Table row field for the configuration packet
  function [15:0] mrs_field;
    input [2:0] f;
    input [2:0] r;
    begin
      case (f)
        3'd0: mrs_field = {4'h0, t_per[r]};
        3'd1: mrs_field = t_dly[r][15:0];
        3'd2: mrs_field = {4'h0, t_col[r]};
        3'd3: mrs_field = {4'h0, t_row[r]};
        3'd4: mrs_field = {4'h0, t_ncol[r]};
        default: mrs_field = {4'h0, t_nrow[r]};
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // rows before first zero period
  always @* begin
    next_count = 4'h0;
    stop = 1'b0;
    for (kc = 0; kc < 8; kc = kc + 1) begin
      if (!stop && t_per[kc] != 12'h000)
        next_count = next_count + 4'h1;
      else
        stop = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Table writes, cycle count and configuration counter
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (kt = 0; kt < 8; kt = kt + 1) begin
        t_per[kt] <= 12'h000;
        t_dly[kt] <= 24'h00_0000;
        t_col[kt] <= 12'h000;
        t_row[kt] <= 12'h000;
        t_ncol[kt] <= 12'h000;
        t_nrow[kt] <= 12'h000;
      end
      cpr <= `MRS_CPR_RST;
      o_config_count <= `MRS_CC_RST;
      o_active_count <= 4'h0;
    end else begin
      o_active_count <= next_count;
      if (i_row_wr) begin
        t_per[i_row_index] <= i_row_period;
        t_dly[i_row_index] <= i_row_delay;
        t_col[i_row_index] <= i_row_col;
        t_row[i_row_index] <= i_row_start;
        t_ncol[i_row_index] <= i_row_ncol;
        t_nrow[i_row_index] <= i_row_nrow;
        o_config_count <= o_config_count + 8'h01;
      end
      if (i_cpr_wr)
        cpr <= i_cpr_value;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Readout sequencer; link words are one-cycle pulses
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= S_IDLE;
      iter <= 24'h00_0000;
      cur <= 4'h0;
      wcnt <= 4'h0;
      crow <= 4'h0;
      fld <= 3'd0;
      corner <= 2'd0;
      cyc <= 8'h00;
      col <= 12'h000;
      row <= 12'h000;
      dly <= 24'h00_0000;
      frac <= 4'h0;
      for (ks = 0; ks < 8; ks = ks + 1)
        phase[ks] <= 12'h000;
      o_cmd_poll <= 1'b0;
      o_full_frame <= 1'b0;
      o_global_reset <= 1'b0;
      o_coord_word <= 24'h00_0000;
      o_coord_strobe <= 1'b0;
      o_pix_strobe <= 1'b0;
      o_pix_col <= 12'h000;
      o_pix_row <= 12'h000;
      o_link_valid <= 1'b0;
      o_link_k <= 1'b0;
      o_link_data <= 16'h0000;
    end else begin
      o_cmd_poll <= 1'b0;
      o_coord_strobe <= 1'b0;
      o_pix_strobe <= 1'b0;
      o_link_valid <= 1'b0;
      o_link_k <= 1'b0;
      case (state)
        S_IDLE: begin
          if (i_video_on) begin
            o_cmd_poll <= 1'b1;
            state <= S_RST;
            wcnt <= 4'h0;
            crow <= 4'h0;
            fld <= 3'd0;
          end
        end
        S_RST: begin
          o_full_frame <= 1'b1;
          o_global_reset <= 1'b1;
          o_link_valid <= 1'b1;
          if (wcnt < 4'h5)
            wcnt <= wcnt + 4'h1;
          case (wcnt)
            4'h0, 4'h2: begin
              o_link_k <= 1'b1;
              o_link_data <= `MRS_KCHAR;
            end
            4'h1: o_link_data <= `MRS_HDR_RST;
            4'h3: o_link_data <= `MRS_HDR_CFG;
            4'h4: o_link_data <= {8'h00, o_config_count};
            default: begin
              if (crow >= o_active_count) begin
                o_link_valid <= 1'b0;
                o_global_reset <= 1'b0;
                iter <= 24'h00_0001;
                cur <= 4'h0;
                for (ks = 0; ks < 8; ks = ks + 1)
                  phase[ks] <= 12'h000;
                state <= S_ITER;
              end else begin
                o_link_data <= mrs_field(fld, crow[2:0]);
                if (fld == 3'd5) begin
                  fld <= 3'd0;
                  crow <= crow + 4'h1;
                end else begin
                  fld <= fld + 3'd1;
                end
              end
            end
          endcase
        end
        S_ITER: begin
          if (cur >= o_active_count) begin
            if (iter >= cpr) begin
              if (i_video_on) begin
                o_cmd_poll <= 1'b1;
                state <= S_RST;
              end else begin
                o_full_frame <= 1'b0;
                state <= S_IDLE;
              end
              wcnt <= 4'h0;
              crow <= 4'h0;
              fld <= 3'd0;
            end else begin
              iter <= iter + 24'h00_0001;
              cur <= 4'h0;
            end
          end else if (ph_nxt >= t_per[ci]) begin
            // sampled when i mod period is zero
            phase[ci] <= 12'h000;
            o_full_frame <= 1'b0;
            corner <= 2'd0;
            cyc <= 8'h00;
            state <= S_COORD;
          end else begin
            phase[ci] <= ph_nxt;
            cur <= cur + 4'h1;
          end
        end
        // four corners, one per 2.5 us
        S_COORD: begin
          if (cyc == 8'h00) begin
            o_coord_strobe <= 1'b1;
            case (corner)
              2'd0: o_coord_word <= {t_row[ci], t_col[ci]};
              2'd1: o_coord_word <= {t_row[ci],
                t_col[ci] + t_ncol[ci] - 12'h001};
              2'd2: o_coord_word <= {t_row[ci] + t_nrow[ci] - 12'h001,
                t_col[ci]};
              default: o_coord_word <= {t_row[ci] + t_nrow[ci] - 12'h001,
                t_col[ci] + t_ncol[ci] - 12'h001};
            endcase
          end
          if (cyc == COORD_LAST) begin
            cyc <= 8'h00;
            corner <= corner + 2'd1;
            if (corner == 2'd3) begin
              wcnt <= 4'h0;
              state <= S_HDR;
            end
          end else begin
            cyc <= cyc + 8'h01;
          end
        end
        S_HDR: begin
          o_link_valid <= 1'b1;
          if (wcnt == 4'h0) begin
            o_link_k <= 1'b1;
            o_link_data <= `MRS_KCHAR;
            wcnt <= 4'h1;
          end else begin
            o_link_data <= {12'h000, cur + 4'h1};
            col <= 12'h000;
            row <= 12'h000;
            cyc <= 8'h00;
            state <= S_PIX;
          end
        end
        // one channel, one region at a time
        S_PIX: begin
          if (cyc == PIX_LAST) begin
            cyc <= 8'h00;
            o_pix_strobe <= 1'b1;
            o_pix_col <= t_col[ci] + col;
            o_pix_row <= t_row[ci] + row;
            if (col + 12'h001 >= t_ncol[ci]) begin
              col <= 12'h000;
              row <= row + 12'h001;
              if (row + 12'h001 >= t_nrow[ci]) begin
                dly <= t_dly[ci];
                frac <= 4'h0;
                state <= S_DELAY;
              end
            end else begin
              col <= col + 12'h001;
            end
          end else begin
            cyc <= cyc + 8'h01;
          end
        end
        // 24-bit delay in 40 ns ticks
        S_DELAY: begin
          if (dly == 24'h00_0000) begin
            cur <= cur + 4'h1;
            state <= S_ITER;
          end else begin
            frac <= tick ? frac_sum - `MRS_TICK_DEN : frac_sum;
            if (tick)
              dly <= dly - 24'h00_0001;
          end
        end
        default: state <= S_IDLE;
      endcase
      // Converter answers while the strobe stands, so the word goes out
      // one cycle after the strobe; no other state sends then
      if (o_pix_strobe) begin
        o_link_valid <= 1'b1;
        o_link_data <= i_pixel_data;
      end
    end
  end

endmodule // mrs_sequencer
